// ### src/ccl_lock.v
// configuration lock, init handshake and bit-timing engine with apb slave
`timescale 1ns/1ps
`include "ccl_defs.vh"

module ccl_lock
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        osc_clk_pin,
   input  wire        can_rx_pin,
   input  wire        power_down_pin,
   input  wire        special_mode_pin,
   input  wire        proto_tx_bit,
   input  wire        proto_frame_active,
   input  wire [7:0]  rx_err_count,
   input  wire [7:0]  tx_err_count,
   input  wire [7:0]  rflg_set,
   input  wire [2:0]  taak_set,
   output wire        bus_transmit_out,
   output wire        mac_rx_bit,
   output wire        tq_tick,
   output wire        sample_point,
   output wire        transmit_point,
   output wire        frame_abort,
   output wire        bus_synced,
   output wire        tx_start_allowed,
   output wire        init_mode_active,
   output wire        sleep_mode_active
);

   localparam ST_SYNC = 3'b001;
   localparam ST_SEG1 = 3'b010;
   localparam ST_SEG2 = 3'b100;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   reg  [1:0] osc_s_reg;
   reg  [1:0] rx_s_reg;
   reg  [1:0] pd_s_reg;
   reg  [1:0] sm_s_reg;
   reg        osc_d_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_s_reg <= 2'b00;
         rx_s_reg  <= 2'b11;
         pd_s_reg  <= 2'b00;
         sm_s_reg  <= 2'b00;
         osc_d_reg <= 1'b0;
      end
      else if (ce)
      begin
         osc_s_reg <= {osc_s_reg[0], osc_clk_pin};
         rx_s_reg  <= {rx_s_reg[0], can_rx_pin};
         pd_s_reg  <= {pd_s_reg[0], power_down_pin};
         sm_s_reg  <= {sm_s_reg[0], special_mode_pin};
         osc_d_reg <= osc_s_reg[1];
      end
   end

   wire pd      = pd_s_reg[1];
   wire special = sm_s_reg[1];

   // ***********************************************
   // control state
   // ***********************************************
   reg        init_req_reg;
   reg        init_ack_reg;
   reg  [1:0] init_b_reg;
   reg  [2:0] init_p_reg;
   reg        init_q_reg;
   reg        sleep_req_reg;
   reg        sleep_ack_reg;
   reg        wake_en_reg;
   reg        enable_reg;
   reg        ena_wr_reg;
   reg        listen_reg;
   reg        clk_sel_reg;
   reg        three_reg;
   reg  [5:0] presc_reg;
   reg  [1:0] jump_reg;
   reg  [3:0] seg1_len_reg;
   reg  [2:0] seg2_len_reg;
   reg  [7:0] idac_reg;
   reg  [7:0] rflg_reg;
   reg  [7:0] rier_reg;
   reg  [7:0] tier_reg;
   reg  [2:0] tarq_reg;
   reg  [2:0] taak_reg;
   reg  [2:0] tbsel_reg;
   reg  [31:0] prdata_reg;
   reg        pslverr_reg;

   wire       init_mode  = init_req_reg & init_ack_reg;
   wire       sleep_mode = sleep_req_reg & sleep_ack_reg;
   wire       unlock     = init_mode | special;
   wire       wr         = psel & penable & pwrite;
   wire [7:0] wd         = pwdata[7:0];
   wire       filt_hit   = (paddr[7:6] == `CCL_FILT_PAGE);
   wire [3:0] filt_idx   = paddr[5:2];

   // ***********************************************
   // acceptance code and mask bytes
   // ***********************************************
   wire [127:0] filt_flat;
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_filt
         reg [7:0] byte_reg;
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               byte_reg <= `CCL_RST_BYTE;
            else if (ce && wr && unlock && filt_hit && filt_idx == gi)
               byte_reg <= wd;
         end
         assign filt_flat[gi*8 +: 8] = byte_reg;
      end
   endgenerate

   // ***********************************************
   // register writes and mode handshakes
   // ***********************************************
   wire w_ctl0 = wr && paddr == `CCL_OFS_CTL0;
   wire w_ctl1 = wr && paddr == `CCL_OFS_CTL1;
   wire ptick;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_req_reg  <= 1'b0;
         init_ack_reg  <= 1'b0;
         init_b_reg    <= 2'b00;
         init_p_reg    <= 3'b000;
         init_q_reg    <= 1'b0;
         sleep_req_reg <= 1'b0;
         sleep_ack_reg <= 1'b0;
         wake_en_reg   <= 1'b0;
         enable_reg    <= 1'b0;
         ena_wr_reg    <= 1'b0;
         listen_reg    <= 1'b0;
         clk_sel_reg   <= 1'b0;
         three_reg     <= 1'b0;
         presc_reg     <= `CCL_RST_PRESC;
         jump_reg      <= `CCL_RST_JUMP;
         seg1_len_reg  <= `CCL_RST_SEG1;
         seg2_len_reg  <= `CCL_RST_SEG2;
         idac_reg      <= `CCL_RST_BYTE;
         rflg_reg      <= `CCL_RST_BYTE;
         rier_reg      <= `CCL_RST_BYTE;
         tier_reg      <= `CCL_RST_BYTE;
         tarq_reg      <= 3'b000;
         taak_reg      <= 3'b000;
         tbsel_reg     <= 3'b000;
      end
      else if (ce)
      begin
         // two bus-clock stages, then three protocol-clock stages
         init_b_reg <= {init_b_reg[0], init_req_reg};
         if (ptick)
            init_p_reg <= {init_p_reg[1:0], init_b_reg[1]};
         init_ack_reg <= init_p_reg[2];
         init_q_reg   <= init_req_reg;

         if (w_ctl0)
         begin
            if (wd[`CCL_C0_INIT_REQ] || init_mode || special)
               init_req_reg <= wd[`CCL_C0_INIT_REQ];
            if (wd[`CCL_C0_SLEEP_REQ] || sleep_mode || special)
               sleep_req_reg <= wd[`CCL_C0_SLEEP_REQ];
            wake_en_reg <= wd[`CCL_C0_WAKE];
         end

         if (w_ctl1)
         begin
            if (!ena_wr_reg || special)
            begin
               enable_reg <= wd[`CCL_C1_ENABLE];
               ena_wr_reg <= 1'b1;
               if (wd[`CCL_C1_ENABLE] && !enable_reg)
                  init_req_reg <= 1'b1;
            end
            if (unlock)
            begin
               listen_reg <= wd[`CCL_C1_LISTEN];
               clk_sel_reg <= wd[`CCL_C1_CLK_SEL];
            end
         end

         if (wr && unlock && paddr == `CCL_OFS_BTR0)
         begin
            presc_reg <= wd[5:0];
            jump_reg  <= wd[7:6];
         end
         if (wr && unlock && paddr == `CCL_OFS_BTR1)
         begin
            seg1_len_reg <= wd[3:0];
            seg2_len_reg <= wd[6:4];
            three_reg <= wd[`CCL_B1_THREE];
         end
         if (wr && unlock && paddr == `CCL_OFS_IDAC)
            idac_reg <= wd;

         // sleep is granted only once no frame is on the wire
         if (!sleep_req_reg)
            sleep_ack_reg <= 1'b0;
         else if (enable_reg && !proto_frame_active)
            sleep_ack_reg <= 1'b1;

         // defaults already land on the edge the acknowledge rises, so sleep
         // never reads active alongside init mode
         if (init_mode || (init_req_reg && init_p_reg[2]))
         begin
            // status and control fields held at defaults
            sleep_req_reg <= 1'b0;
            wake_en_reg   <= 1'b0;
            rflg_reg      <= `CCL_RST_BYTE;
            rier_reg      <= `CCL_RST_BYTE;
            tier_reg      <= `CCL_RST_BYTE;
            tarq_reg      <= 3'b000;
            taak_reg      <= 3'b000;
            tbsel_reg     <= 3'b000;
         end
         else
         begin
            // a new event outranks the write-one-to-clear in the same cycle
            rflg_reg <= rflg_set | (rflg_reg & ~((wr && paddr == `CCL_OFS_RFLG) ? wd : 8'h00));
            taak_reg <= taak_set | (taak_reg & ~tarq_reg);
            if (wr && paddr == `CCL_OFS_RIER)
               rier_reg <= wd;
            if (wr && paddr == `CCL_OFS_TIER)
               tier_reg <= wd;
            if (wr && paddr == `CCL_OFS_TARQ)
               tarq_reg <= wd[2:0];
            if (wr && paddr == `CCL_OFS_TBSEL)
               tbsel_reg <= wd[2:0];
         end
      end
   end

   // ***********************************************
   // protocol clock and prescaler
   // ***********************************************
   // disabled module: protocol clock stands still
   assign ptick = enable_reg & (clk_sel_reg | (osc_s_reg[1] & ~osc_d_reg));
   wire run = enable_reg & ~init_req_reg & ~init_ack_reg & ~sleep_mode & ~pd;

   reg  [5:0] presc_cnt_reg;
   wire       tq_pulse = run & ptick & (presc_cnt_reg == presc_reg);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc_cnt_reg <= 6'h00;
      else if (ce)
      begin
         if (!run)
            presc_cnt_reg <= 6'h00;
         else if (tq_pulse)
            presc_cnt_reg <= 6'h00;
         else if (ptick)
            presc_cnt_reg <= presc_cnt_reg + 6'h01;
      end
   end

   // ***********************************************
   // bit segment engine
   // ***********************************************
   reg  [2:0] st_reg;
   reg  [4:0] cnt_reg;
   reg  [4:0] ext_reg;
   reg        edge_pend_reg;
   reg        rx_prev_reg;
   reg  [1:0] smp_reg;
   reg        rx_bit_reg;
   reg        sp_reg;
   reg        tp_reg;
   reg        tq_reg;
   reg  [3:0] rec_cnt_reg;
   reg        sync_reg;
   reg        abort_reg;
   reg        tx_reg;

   // loopback keeps the mac seeing its own dominant bit in listen-only
   wire       mac_rx  = rx_s_reg[1] & (listen_reg ? proto_tx_bit : 1'b1);
   wire [4:0] e1      = cnt_reg + 5'd1;
   wire [4:0] sjq     = {3'b000, jump_reg} + 5'd1;
   wire [4:0] ext_now = (edge_pend_reg && ext_reg == 5'd0) ? ((e1 < sjq) ? e1 : sjq) : ext_reg;
   wire [4:0] seg1_end = {1'b0, seg1_len_reg} + ext_now;
   wire [4:0] rem2    = {2'b00, seg2_len_reg} - cnt_reg;
   wire       maj     = (smp_reg[1] & smp_reg[0]) | (smp_reg[1] & mac_rx) | (smp_reg[0] & mac_rx);
   wire       smp_bit = three_reg ? maj : mac_rx;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg        <= ST_SYNC;
         cnt_reg       <= 5'd0;
         ext_reg       <= 5'd0;
         edge_pend_reg <= 1'b0;
         rx_prev_reg   <= `CCL_REC_LEVEL;
         smp_reg       <= 2'b11;
         rx_bit_reg    <= `CCL_REC_LEVEL;
         sp_reg        <= 1'b0;
         tp_reg        <= 1'b0;
         tq_reg        <= 1'b0;
      end
      else if (ce)
      begin
         rx_prev_reg <= mac_rx;
         sp_reg      <= 1'b0;
         tp_reg      <= 1'b0;
         tq_reg      <= tq_pulse;
         if (!run)
         begin
            st_reg        <= ST_SYNC;
            cnt_reg       <= 5'd0;
            ext_reg       <= 5'd0;
            edge_pend_reg <= 1'b0;
         end
         else if (!tq_pulse)
         begin
            if (rx_prev_reg && !mac_rx)
               edge_pend_reg <= 1'b1;
         end
         else
         begin
            edge_pend_reg <= 1'b0;
            case (st_reg)
               ST_SYNC:
               begin
                  st_reg  <= ST_SEG1;
                  cnt_reg <= 5'd0;
                  ext_reg <= 5'd0;
               end
               ST_SEG1:
               begin
                  ext_reg <= ext_now;
                  smp_reg <= {smp_reg[0], mac_rx};
                  if (cnt_reg >= seg1_end)
                  begin
                     st_reg     <= ST_SEG2;
                     cnt_reg    <= 5'd0;
                     sp_reg     <= 1'b1;
                     rx_bit_reg <= smp_bit;
                  end
                  else
                     cnt_reg <= e1;
               end
               ST_SEG2:
               begin
                  // early edge: shorten by at most the jump width plus the elapsed count plus one
                  if (edge_pend_reg && rem2 <= sjq)
                  begin
                     st_reg  <= ST_SEG1;
                     cnt_reg <= 5'd0;
                     ext_reg <= 5'd0;
                     tp_reg  <= 1'b1;
                  end
                  else if (cnt_reg >= {2'b00, seg2_len_reg} || edge_pend_reg && rem2 <= e1 + sjq)
                  begin
                     st_reg <= ST_SYNC;
                     tp_reg <= 1'b1;
                  end
                  else if (edge_pend_reg)
                     cnt_reg <= cnt_reg + sjq;
                  else
                     cnt_reg <= e1;
               end
               default:
                  st_reg <= ST_SYNC;
            endcase
         end
      end
   end

   // ***********************************************
   // bus sync, abort and transmit pin
   // ***********************************************
   wire force_rec = ~enable_reg | init_req_reg | init_ack_reg | pd | listen_reg | sleep_mode;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rec_cnt_reg <= 4'h0;
         sync_reg    <= 1'b0;
         abort_reg   <= 1'b0;
         tx_reg      <= `CCL_REC_LEVEL;
      end
      else if (ce)
      begin
         abort_reg <= enable_reg & init_req_reg & ~init_q_reg;
         tx_reg    <= force_rec ? `CCL_REC_LEVEL : proto_tx_bit;
         if (!run)
         begin
            sync_reg    <= 1'b0;
            rec_cnt_reg <= 4'h0;
         end
         else if (sp_reg && !sync_reg)
         begin
            // resume only after a run of recessive bits
            if (!rx_bit_reg)
               rec_cnt_reg <= 4'h0;
            else if (rec_cnt_reg == `CCL_IDLE_BITS - 4'h1)
               sync_reg <= 1'b1;
            else
               rec_cnt_reg <= rec_cnt_reg + 4'h1;
         end
      end
   end

   // ***********************************************
   // apb read path
   // ***********************************************
   reg [7:0] rd_byte;
   reg       rd_ok;

   always @*
   begin
      rd_ok = 1'b1;
      case (paddr)
         `CCL_OFS_CTL0:  rd_byte = {5'b0, wake_en_reg, sleep_req_reg, init_req_reg};
         `CCL_OFS_CTL1:  rd_byte = {enable_reg, clk_sel_reg, 1'b0, listen_reg, 2'b0,
                                    sleep_ack_reg, init_ack_reg};
         `CCL_OFS_BTR0:  rd_byte = {jump_reg, presc_reg};
         `CCL_OFS_BTR1:  rd_byte = {three_reg, seg2_len_reg, seg1_len_reg};
         `CCL_OFS_RFLG:  rd_byte = rflg_reg;
         `CCL_OFS_RIER:  rd_byte = rier_reg;
         `CCL_OFS_TIER:  rd_byte = tier_reg;
         `CCL_OFS_TARQ:  rd_byte = {5'b0, tarq_reg};
         `CCL_OFS_TAAK:  rd_byte = {5'b0, taak_reg};
         `CCL_OFS_TBSEL: rd_byte = {5'b0, tbsel_reg};
         `CCL_OFS_IDAC:  rd_byte = idac_reg;
         `CCL_OFS_RXERR: rd_byte = rx_err_count;
         `CCL_OFS_TXERR: rd_byte = tx_err_count;
         `CCL_OFS_STAT:  rd_byte = {3'b0, ena_wr_reg, special, sleep_mode, init_mode, sync_reg};
         default:
         begin
            rd_byte = filt_flat[filt_idx*8 +: 8];
            rd_ok   = filt_hit;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
      else if (ce && psel && !penable)
      begin
         prdata_reg  <= (pwrite || !rd_ok) ? 32'h00000000 : {24'h000000, rd_byte};
         pslverr_reg <= ~rd_ok;
      end
   end

   assign prdata            = prdata_reg;
   assign pready            = 1'b1;
   assign pslverr           = pslverr_reg & psel & penable;
   assign bus_transmit_out  = tx_reg;
   assign mac_rx_bit        = rx_bit_reg;
   assign tq_tick           = tq_reg;
   assign sample_point      = sp_reg;
   assign transmit_point    = tp_reg;
   assign frame_abort       = abort_reg;
   assign bus_synced        = sync_reg;
   assign tx_start_allowed  = run & sync_reg & ~listen_reg;
   assign init_mode_active  = init_mode;
   assign sleep_mode_active = sleep_mode;

endmodule // ccl_lock

// ### src/ccl_defs.vh
// constants for the protocol-controller configuration lock and bit-timing block
`ifndef CCL_DEFS_VH
`define CCL_DEFS_VH

// ***********************************************
// register byte offsets
// ***********************************************
`define CCL_OFS_CTL0     8'h00
`define CCL_OFS_CTL1     8'h04
`define CCL_OFS_BTR0     8'h08
`define CCL_OFS_BTR1     8'h0c
`define CCL_OFS_RFLG     8'h10
`define CCL_OFS_RIER     8'h14
`define CCL_OFS_TIER     8'h18
`define CCL_OFS_TARQ     8'h1c
`define CCL_OFS_TAAK     8'h20
`define CCL_OFS_TBSEL    8'h24
`define CCL_OFS_IDAC     8'h28
`define CCL_OFS_RXERR    8'h2c
`define CCL_OFS_TXERR    8'h30
`define CCL_OFS_STAT     8'h34
`define CCL_FILT_PAGE    2'b01

// ***********************************************
// field positions
// ***********************************************
`define CCL_C0_INIT_REQ  0
`define CCL_C0_SLEEP_REQ 1
`define CCL_C0_WAKE      2
`define CCL_C1_INIT_ACK  0
`define CCL_C1_SLEEP_ACK 1
`define CCL_C1_LISTEN    4
`define CCL_C1_CLK_SEL   6
`define CCL_C1_ENABLE    7
`define CCL_B1_THREE     7

// ***********************************************
// reset values and timing
// ***********************************************
`define CCL_RST_BYTE     8'h00
`define CCL_RST_PRESC    6'h00
`define CCL_RST_SEG1     4'h3
`define CCL_RST_SEG2     3'h1
`define CCL_RST_JUMP     2'h0
`define CCL_IDLE_BITS    4'hb
`define CCL_REC_LEVEL    1'b1

`endif

// ### test/ccl_lock_asserts.sv
// concurrent checks on the configuration lock block ports
`timescale 1ns/1ps
module ccl_lock_asserts
(
   input wire pclk,
   input wire presetn,
   input wire bus_transmit_out,
   input wire frame_abort,
   input wire bus_synced,
   input wire sample_point,
   input wire transmit_point,
   input wire tx_start_allowed,
   input wire init_mode_active,
   input wire sleep_mode_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***********************************
   // assertions
   // ***********************************
   AST_TX_INIT: assert property (init_mode_active |-> bus_transmit_out)
      else $error("tx pin dominant in init mode");
   AST_ABORT_TX: assert property (frame_abort |-> bus_transmit_out)
      else $error("tx pin dominant at abort");
   AST_ABORT_PULSE: assert property (frame_abort |=> !frame_abort)
      else $error("abort pulse too long");
   AST_ABORT_SYNC: assert property (frame_abort |=> !bus_synced)
      else $error("sync kept after abort");
   AST_INIT_STOP: assert property (init_mode_active |-> !bus_synced)
      else $error("protocol synced in init mode");
   AST_INIT_SLEEP: assert property (init_mode_active |-> !sleep_mode_active)
      else $error("sleep active in init mode");
   // sync plus the reset-length first segment spans five quanta
   AST_SYNC_SEG: assert property (transmit_point |=> !sample_point [*4])
      else $error("sample point too early");
   AST_START_SYNC: assert property (tx_start_allowed |-> bus_synced)
      else $error("start allowed while unsynced");
   // ***********************************
   // covers
   // ***********************************
   cover property ($rose(init_mode_active));
   cover property (frame_abort);
   cover property ($rose(bus_synced));
endmodule // ccl_lock_asserts

bind ccl_lock ccl_lock_asserts u_chk (.pclk, .presetn, .bus_transmit_out, .frame_abort,
   .bus_synced, .sample_point, .transmit_point, .tx_start_allowed, .init_mode_active,
   .sleep_mode_active);

// ### test/ccl_node.sv
// far-side bus node: wired-and bus with a dominant pull on command
`timescale 1ns/1ps
module ccl_node
(
   input  wire tx,
   input  wire dom,
   output wire rx
);
   // recessive unless either party pulls it dominant
   assign rx = tx & ~dom;
endmodule // ccl_node

// ### test/tb_ccl_lock.sv
// self-checking bench for the configuration lock block
`timescale 1ns/1ps
module tb_ccl_lock;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, rx_err_count = 8'h3a;
   logic [31:0] pwdata = 32'h0, rd;
   logic        se, q, osc_clk_pin = 0, power_down_pin = 0, special_mode_pin = 0;
   logic        proto_tx_bit = 1, dom = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, can_rx_pin, bus_transmit_out, mac_rx_bit, tq_tick;
   wire         sample_point, transmit_point, frame_abort, bus_synced;
   wire         tx_start_allowed, init_mode_active, sleep_mode_active;
   int          fail_count = 0, samples_checked = 0, cyc = 0, n;

   always #50 pclk = ~pclk;
   always #370 osc_clk_pin = ~osc_clk_pin;

   ccl_lock dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .osc_clk_pin, .can_rx_pin, .power_down_pin,
      .special_mode_pin, .proto_tx_bit, .proto_frame_active(1'b0), .rx_err_count,
      .tx_err_count(8'hc5), .rflg_set(8'h00), .taak_set(3'h0), .bus_transmit_out,
      .mac_rx_bit, .tq_tick, .sample_point, .transmit_point, .frame_abort, .bus_synced,
      .tx_start_allowed, .init_mode_active, .sleep_mode_active);
   ccl_node far (.tx(bus_transmit_out), .dom, .rx(can_rx_pin));

   // ***********************************
   // shared tasks
   // ***********************************
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task wack(input logic v);
      n = 0;
      do
      begin
         apb(0, 8'h04, 0);
         n++;
      end
      while (rd[0] !== v && n < 40);
      chk("init ack", rd[0], v);
   endtask

   task step(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask

   task wsync;
      n = 0;
      while (bus_synced !== 1'b1 && n < 600)
      begin
         step(1);
         n++;
      end
      chk("synced", bus_synced, 1);
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task t_start;
      apb(0, 8'h04, 0);
      chk("ctl1 reset", rd, 0);
      apb(0, 8'h0c, 0);
      chk("btr1 reset", rd, 32'h13);
      apb(1, 8'h04, 32'hc0);
      apb(1, 8'h00, 0);
      apb(0, 8'h04, 0);
      chk("early ack", rd[0], 0);
      apb(0, 8'h00, 0);
      chk("init req", rd[0], 1);
      wack(1);
      $display("start done");
   endtask

   task t_lock;
      apb(1, 8'h08, 32'h41);
      apb(1, 8'h0c, 32'h25);
      apb(1, 8'h40, 32'ha5);
      apb(1, 8'h04, 32'h40);
      apb(0, 8'h04, 0);
      chk("enable once", rd[7], 1);
      apb(0, 8'h0c, 0);
      chk("btr1 init", rd, 32'h25);
      rx_err_count <= 8'h5a;
      apb(1, 8'h2c, 32'hff);
      apb(0, 8'h2c, 0);
      chk("rx err", rd, 32'h5a);
      apb(1, 8'h30, 32'h00);
      apb(0, 8'h30, 0);
      chk("tx err", rd, 32'hc5);
      apb(0, 8'h38, 0);
      chk("unmapped", {rd[0], se}, 2'b01);
      apb(1, 8'h00, 0);
      wack(0);
      apb(1, 8'h08, 32'h3f);
      apb(0, 8'h08, 0);
      chk("btr0 locked", rd, 32'h41);
      apb(1, 8'h40, 32'h5a);
      apb(0, 8'h40, 0);
      chk("filter locked", rd, 32'ha5);
      $display("lock done");
   endtask

   task t_sync;
      dom <= 1;
      step(300);
      chk("dominant bus", bus_synced, 0);
      dom <= 0;
      wsync;
      q = tq_tick;
      step(1);
      chk("tq tick", tq_tick, !q);
      while (transmit_point !== 1'b1) step(1);
      n = 0;
      do begin step(1); n++; end while (sample_point !== 1'b1);
      chk("seg1 span", n, 14);
      do begin step(1); n++; end while (transmit_point !== 1'b1);
      chk("bit span", n, 20);
      proto_tx_bit <= 0;
      step(2);
      chk("tx follows", {bus_transmit_out, tx_start_allowed}, 2'b01);
      power_down_pin <= 1;
      step(4);
      chk("tx power down", bus_transmit_out, 1);
      power_down_pin <= 0;
      proto_tx_bit <= 1;
      wsync;
      proto_tx_bit <= 0;
      step(2);
      apb(1, 8'h00, 1);
      step(1);
      chk("abort", {frame_abort, bus_transmit_out}, 2'b11);
      step(1);
      chk("sync lost", bus_synced, 0);
      proto_tx_bit <= 1;
      wack(1);
      $display("sync done");
   endtask

   task t_listen;
      apb(1, 8'h04, 32'h50);
      apb(1, 8'h00, 0);
      wack(0);
      wsync;
      chk("no start", tx_start_allowed, 0);
      proto_tx_bit <= 0;
      step(60);
      chk("tx listen", bus_transmit_out, 1);
      chk("loopback", mac_rx_bit, 0);
      proto_tx_bit <= 1;
      special_mode_pin <= 1;
      step(4);
      apb(1, 8'h08, 32'h07);
      apb(0, 8'h08, 0);
      chk("special write", rd, 32'h07);
      apb(1, 8'h00, 32'h02);
      step(2);
      chk("sleep", sleep_mode_active, 1);
      apb(1, 8'h00, 32'h03);
      wack(1);
      apb(0, 8'h00, 0);
      chk("ctl0 init", rd, 32'h01);
      chk("sleep in init", sleep_mode_active, 0);
      $display("listen done");
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         end_sim;
      end
   end

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_start;
      t_lock;
      t_sync;
      t_listen;
      end_sim;
   end
endmodule // tb_ccl_lock
